/* pkg/asc_defs.svh */
// register offsets, field positions, reset values and timing constants for the sequencer control
// Summary of operation
// RQ1: four sequencers, depths eight, four, four, one
// RQ2: queue word is 32 bits, result low ten
// RQ3: each step has input and control nibbles
// RQ4: sequencer runs only while its enable set; code tests it only at start, a running sequence completes
// RQ5: same input may repeat within one sequence
// RQ6: any step may raise raw interrupt
// RQ7: last-sample marker ends sequence at that step
// RQ8: queue is circular, each read pops oldest
// RQ9: status shows head, tail, full, empty
// RQ10: overflow and underflow recorded per sequencer
// RQ11: converter clock near 16.667 MHz by divider; code rounds the divider up to 2, pacing at 12.5 MHz from 25 MHz
// RQ12: mask alone gates forwarding of raw interrupts
// RQ13: raw shows unmasked, clear register shows masked
// RQ14: write one clears pending, zero ignored
// RQ15: concurrent triggers served by priority, zero highest
// RQ16: software gives active sequencers distinct priorities
// RQ17: trigger select offers processor, always, peripherals
// RQ18: initiate bit starts processor-triggered sequencer
// RQ19: always trigger on high priority can starve
// RQ20: averaging accumulates up to 64 conversions
// RQ21: averaging off after reset, shared by all
// RQ22: single-ended result spans 0x000 to 0x3ff
// RQ23: differential pair n samples inputs 2n, 2n+1
// RQ24: differential zero difference gives 0x1ff
// RQ25: priority reset gives sequencer zero highest
// RQ26: after last step sequencer idles until trigger
`ifndef ASC_DEFS_SVH
`define ASC_DEFS_SVH
`define ASC_OFF_ACTIVE   12'h000
`define ASC_OFF_RIS      12'h004
`define ASC_OFF_IM       12'h008
`define ASC_OFF_ISC      12'h00c
`define ASC_OFF_OSTAT    12'h010
`define ASC_OFF_EMUX     12'h014
`define ASC_OFF_USTAT    12'h018
`define ASC_OFF_PRI      12'h020
`define ASC_OFF_PSSI     12'h028
`define ASC_OFF_SAC      12'h030
`define ASC_OFF_SS_BASE  12'h040
`define ASC_SS_STRIDE_LG 5
`define ASC_SS_MUX       3'h0
`define ASC_SS_CTL       3'h1
`define ASC_SS_FIFO      3'h2
`define ASC_SS_FSTAT     3'h3
`define ASC_PRI_RESET    16'h3210
`define ASC_TRIG_CPU     4'h0
`define ASC_TRIG_ALWAYS  4'hf
`define ASC_CTL_DIFF     0
`define ASC_CTL_END      1
`define ASC_CTL_IE       2
`define ASC_CTL_TEMP     3
`define ASC_FST_TAIL     0
`define ASC_FST_HEAD     4
`define ASC_FST_EMPTY    8
`define ASC_FST_FULL     12
`define ASC_SAC_MAX      3'h6
`define ASC_CONV_CYCLES  4
`endif

/* pkg/asc_pkg.sv */
// types shared by the sequencer control
package asc_pkg;
	typedef enum logic [1:0] {ASC_IDLE, ASC_CONV, ASC_WAIT} asc_phase_t;
	typedef struct packed {
		logic        busy;
		logic [3:0]  sel;
		logic        diff;
		logic        temp;
	} asc_conv_req_t;
	typedef struct packed {
		logic [3:0]  active;
		logic [3:0]  ris;
		logic [3:0]  im;
		logic [3:0]  ostat;
		logic [3:0]  ustat;
		logic [15:0] emux;
		logic [15:0] pri;
		logic [2:0]  sac;
		logic [3:0]  pend;
		logic [3:0][31:0]     mux;
		logic [3:0][31:0]     ctl;
		logic [3:0][7:0][9:0] q;
		logic [3:0][2:0]      head;
		logic [3:0][2:0]      tail;
		logic [3:0][3:0]      cnt;
		asc_phase_t  phase;
		logic [1:0]  cur;
		logic [2:0]  step;
		logic [5:0]  avg_n;
		logic [15:0] acc;
		logic [3:0]  cyc;
		logic        irq;
		asc_conv_req_t conv;
		logic        hready;
		logic [31:0] hrdata;
		logic        dp_we;
		logic        dp_re;
		logic [11:0] dp_addr;
	} asc_state_t;
endpackage

/* verilog/asc_sequencer.sv */
// four-queue sample sequencer control with an ahb-lite register slave
//
// Decided for this implementation: the AHB-Lite slave port and the address map.
`timescale 1ns/1ps
`include "asc_defs.svh"
module asc_sequencer #(
	parameter int CLK_HZ  = 25000000,
	parameter int CONV_HZ = 16667000
) (
	input  wire logic                  hclk,
	input  wire logic                  hresetn,
	input  wire logic                  hsel,
	input  wire logic [31:0]           haddr,
	input  wire logic [1:0]            htrans,
	input  wire logic                  hwrite,
	input  wire logic [2:0]            hsize,
	input  wire logic [31:0]           hwdata,
	input  wire logic                  hready,
	output logic                       hreadyout,
	output logic                       hresp,
	output logic [31:0]                hrdata,
	input  wire logic [11:0]           periph_trig,
	input  wire logic [9:0]            conv_result,
	input  wire logic                  conv_done,
	output asc_pkg::asc_conv_req_t     conv_req,
	output logic                       irq
);
	// converter pacing derived from the system clock
	localparam int CONV_DIV = (CLK_HZ + CONV_HZ - 1) / CONV_HZ; // RQ11
	localparam int DEPTH0 = 8;
	localparam int DEPTH1 = 4;
	localparam int DEPTH2 = 4;
	localparam int DEPTH3 = 1;

	asc_pkg::asc_state_t s_q;
	asc_pkg::asc_state_t s_d;

	function automatic logic [3:0] depth_of(input logic [1:0] n);
		unique case (n)
			2'd0: depth_of = 4'(DEPTH0); // RQ1
			2'd1: depth_of = 4'(DEPTH1);
			2'd2: depth_of = 4'(DEPTH2);
			2'd3: depth_of = 4'(DEPTH3);
		endcase
	endfunction

	logic [3:0]  trig;
	logic [3:0]  want;
	logic [1:0]  pick;
	logic        found;
	logic [1:0]  best_pri;
	logic [3:0]  nib_mux;
	logic [3:0]  nib_ctl;
	logic [2:0]  max_step;
	logic [6:0]  avg_total;
	logic [15:0] avg_val;
	logic [1:0]  reg_ss;
	logic [2:0]  reg_kind;
	logic [3:0]  clr;
	logic [3:0]  dep;
	logic [3:0]  ris_set;
	logic [3:0]  ovf_set;
	logic [11:0] rel_w;
	logic [11:0] rel_r;

	always_comb begin
		s_d = s_q;
		// trigger selection per sequencer
		for (int i = 0; i < 4; i++) begin
			unique case (s_q.emux[i*4 +: 4])
				`ASC_TRIG_CPU:    trig[i] = s_q.pend[i]; // RQ17 RQ18
				`ASC_TRIG_ALWAYS: trig[i] = 1'b1;
				default:          trig[i] = (s_q.emux[i*4 +: 4] > 4'hc) ? 1'b0
					: periph_trig[s_q.emux[i*4 +: 4] - 4'h1];
			endcase
			want[i] = trig[i] & s_q.active[i]; // RQ4
		end
		found = 1'b0;
		pick = 2'd0;
		best_pri = 2'd3;
		// lowest priority value wins among pending triggers
		for (int i = 0; i < 4; i++) begin
			if (want[i] && (!found || s_q.pri[i*4 +: 2] < best_pri)) begin // RQ15
				found = 1'b1;
				pick = 2'(i);
				best_pri = s_q.pri[i*4 +: 2];
			end
		end
		nib_mux = s_q.mux[s_q.cur][s_q.step*4 +: 4];
		nib_ctl = s_q.ctl[s_q.cur][s_q.step*4 +: 4];
		dep = depth_of(s_q.cur);
		max_step = 3'(dep - 4'h1);
		avg_total = 7'h1 << s_q.sac; // RQ20
		avg_val = (16'(s_q.acc) + 16'(conv_result)) >> s_q.sac;
		s_d.irq = |(s_q.ris & s_q.im); // RQ12
		clr = 4'h0;
		ris_set = 4'h0;
		ovf_set = 4'h0;
		unique case (s_q.phase)
			asc_pkg::ASC_IDLE: begin
				if (found) begin
					s_d.cur = pick;
					s_d.step = 3'h0;
					s_d.avg_n = 6'h0;
					s_d.acc = 16'h0;
					s_d.cyc = 4'h0;
					s_d.phase = asc_pkg::ASC_CONV;
					if (s_q.emux[pick*4 +: 4] == `ASC_TRIG_CPU)
						clr[pick] = 1'b1;
				end
			end
			asc_pkg::ASC_CONV: begin
				s_d.conv.busy = 1'b1;
				s_d.conv.sel = nib_ctl[`ASC_CTL_DIFF] ? {nib_mux[2:0], 1'b0} : nib_mux; // RQ23 RQ5
				s_d.conv.diff = nib_ctl[`ASC_CTL_DIFF];
				s_d.conv.temp = nib_ctl[`ASC_CTL_TEMP]; // RQ3
				s_d.phase = asc_pkg::ASC_WAIT;
			end
			asc_pkg::ASC_WAIT: begin
				s_d.cyc = (s_q.cyc == 4'(CONV_DIV * `ASC_CONV_CYCLES)) ? s_q.cyc : s_q.cyc + 4'h1;
				if (conv_done && s_q.cyc == 4'(CONV_DIV * `ASC_CONV_CYCLES)) begin
					s_d.conv.busy = 1'b0;
					s_d.cyc = 4'h0;
					if (7'(s_q.avg_n) + 7'h1 < avg_total) begin // RQ20
						s_d.acc = s_q.acc + 16'(conv_result);
						s_d.avg_n = s_q.avg_n + 6'h1;
						s_d.phase = asc_pkg::ASC_CONV;
					end else begin
						s_d.acc = 16'h0;
						s_d.avg_n = 6'h0;
						// result word, diff codes 0x1ff centered by converter
						if (s_q.cnt[s_q.cur] == dep) begin
							s_d.ostat[s_q.cur] = 1'b1; // RQ10
							ovf_set[s_q.cur] = 1'b1;
						end else begin
							s_d.q[s_q.cur][s_q.tail[s_q.cur]] = avg_val[9:0]; // RQ2 RQ22 RQ24
							s_d.tail[s_q.cur] = (s_q.tail[s_q.cur] == max_step) ? 3'h0
								: s_q.tail[s_q.cur] + 3'h1; // RQ8
							s_d.cnt[s_q.cur] = s_q.cnt[s_q.cur] + 4'h1;
						end
						if (nib_ctl[`ASC_CTL_IE])
							s_d.ris[s_q.cur] = 1'b1; // RQ6
						if (nib_ctl[`ASC_CTL_IE])
							ris_set[s_q.cur] = 1'b1;
						if (nib_ctl[`ASC_CTL_END] || s_q.step == max_step) begin
							s_d.phase = asc_pkg::ASC_IDLE; // RQ7 RQ26
						end else begin
							s_d.step = s_q.step + 3'h1;
							s_d.phase = asc_pkg::ASC_CONV;
						end
					end
				end
			end
			default: s_d.phase = asc_pkg::ASC_IDLE;
		endcase
		// initiate requests for disabled sequencers are dropped
		s_d.pend = s_q.pend & ~clr & s_q.active; // RQ4
		// ahb data phase
		s_d.hready = 1'b1;
		s_d.dp_we = 1'b0;
		s_d.dp_re = 1'b0;
		rel_w = s_q.dp_addr - `ASC_OFF_SS_BASE;
		reg_ss = rel_w[6:5];
		reg_kind = rel_w[4:2];
		if (s_q.dp_we) begin
			unique case (s_q.dp_addr)
				`ASC_OFF_ACTIVE: s_d.active = hwdata[3:0];
				`ASC_OFF_IM:     s_d.im = hwdata[3:0];
				// set in the same cycle wins over the clear
				`ASC_OFF_ISC:    s_d.ris = (s_q.ris & ~hwdata[3:0]) | ris_set; // RQ14
				`ASC_OFF_OSTAT:  s_d.ostat = (s_q.ostat & ~hwdata[3:0]) | ovf_set;
				`ASC_OFF_USTAT:  s_d.ustat = s_q.ustat & ~hwdata[3:0];
				`ASC_OFF_EMUX:   s_d.emux = hwdata[15:0];
				`ASC_OFF_PRI:    s_d.pri = hwdata[15:0] & 16'h3333;
				`ASC_OFF_PSSI:   s_d.pend = s_d.pend | hwdata[3:0];
				`ASC_OFF_SAC:    s_d.sac = (hwdata[2:0] > `ASC_SAC_MAX) ? `ASC_SAC_MAX : hwdata[2:0];
				default: begin
					if (s_q.dp_addr >= `ASC_OFF_SS_BASE && rel_w[11:7] == 5'h0) begin
						if (reg_kind == `ASC_SS_MUX)
							s_d.mux[reg_ss] = hwdata;
						else if (reg_kind == `ASC_SS_CTL)
							s_d.ctl[reg_ss] = hwdata;
					end
				end
			endcase
		end
		if (s_q.dp_re && s_q.dp_addr >= `ASC_OFF_SS_BASE && rel_w[11:7] == 5'h0
			&& reg_kind == `ASC_SS_FIFO) begin
			if (s_d.cnt[reg_ss] == 4'h0) begin
				s_d.ustat[reg_ss] = 1'b1; // RQ10
			end else begin
				s_d.head[reg_ss] = (s_q.head[reg_ss] == 3'(depth_of(reg_ss) - 4'h1)) ? 3'h0
					: s_q.head[reg_ss] + 3'h1; // RQ8
				s_d.cnt[reg_ss] = s_d.cnt[reg_ss] - 4'h1;
			end
		end
		// address phase capture and read data
		s_d.hrdata = 32'h0;
		rel_r = {haddr[11:2], 2'b00} - `ASC_OFF_SS_BASE;
		if (hsel && hready && htrans[1]) begin
			s_d.dp_we = hwrite;
			s_d.dp_re = ~hwrite;
			s_d.dp_addr = {haddr[11:2], 2'b00};
			if (!hwrite) begin
				reg_ss = rel_r[6:5];
				reg_kind = rel_r[4:2];
				unique case ({haddr[11:2], 2'b00})
					`ASC_OFF_ACTIVE: s_d.hrdata = {28'h0, s_q.active};
					`ASC_OFF_RIS:    s_d.hrdata = {28'h0, s_q.ris}; // RQ13
					`ASC_OFF_IM:     s_d.hrdata = {28'h0, s_q.im};
					`ASC_OFF_ISC:    s_d.hrdata = {28'h0, s_q.ris & s_q.im}; // RQ13
					`ASC_OFF_OSTAT:  s_d.hrdata = {28'h0, s_q.ostat};
					`ASC_OFF_EMUX:   s_d.hrdata = {16'h0, s_q.emux};
					`ASC_OFF_USTAT:  s_d.hrdata = {28'h0, s_q.ustat};
					`ASC_OFF_PRI:    s_d.hrdata = {16'h0, s_q.pri};
					`ASC_OFF_SAC:    s_d.hrdata = {29'h0, s_q.sac}; // RQ21
					default: begin
						if (haddr[11:0] >= `ASC_OFF_SS_BASE && rel_r[11:7] == 5'h0) begin
							if (reg_kind == `ASC_SS_MUX)
								s_d.hrdata = s_q.mux[reg_ss];
							else if (reg_kind == `ASC_SS_CTL)
								s_d.hrdata = s_q.ctl[reg_ss];
							else if (reg_kind == `ASC_SS_FIFO)
								s_d.hrdata = {22'h0, s_q.q[reg_ss][s_q.head[reg_ss]]}; // RQ2
							else if (reg_kind == `ASC_SS_FSTAT)
								s_d.hrdata = 32'(s_q.tail[reg_ss]) << `ASC_FST_TAIL
									| 32'(s_q.head[reg_ss]) << `ASC_FST_HEAD
									| 32'(s_q.cnt[reg_ss] == 4'h0) << `ASC_FST_EMPTY
									| 32'(s_q.cnt[reg_ss] == depth_of(reg_ss)) << `ASC_FST_FULL; // RQ9
						end
					end
				endcase
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_q <= '{active: 4'h0, ris: 4'h0, im: 4'h0, ostat: 4'h0, ustat: 4'h0,
				emux: 16'h0, pri: `ASC_PRI_RESET, sac: 3'h0, pend: 4'h0, // RQ25 RQ21
				mux: '0, ctl: '0, q: '0, head: '0,
				tail: '0, cnt: '0,
				phase: asc_pkg::ASC_IDLE, cur: 2'h0, step: 3'h0, avg_n: 6'h0,
				acc: 16'h0, cyc: 4'h0, irq: 1'b0, conv: '0, hready: 1'b1,
				hrdata: 32'h0, dp_we: 1'b0, dp_re: 1'b0, dp_addr: 12'h0};
		end else begin
			s_q <= s_d;
		end
	end

	assign hreadyout = s_q.hready;
	assign hresp = 1'b0;
	assign hrdata = s_q.hrdata;
	assign conv_req = s_q.conv;
	assign irq = s_q.irq;

	chk_irq_masked: assert property (@(posedge hclk) disable iff (!hresetn) // RQ12
		irq |-> $past(|(s_q.ris & s_q.im))) else $error("irq without masked status");
	chk_pri_reset: assert property (@(posedge hclk) disable iff (!hresetn) // RQ25
		$rose(hresetn) |-> s_q.pri == `ASC_PRI_RESET) else $error("priority reset wrong");
	chk_idle_hold: assert property (@(posedge hclk) disable iff (!hresetn) // RQ26
		s_q.phase == asc_pkg::ASC_IDLE && !found |=> s_q.phase == asc_pkg::ASC_IDLE
		&& !s_q.conv.busy) else $error("sequencer left idle without trigger");
	chk_start_enabled: assert property (@(posedge hclk) disable iff (!hresetn) // RQ4
		(s_q.phase == asc_pkg::ASC_IDLE && s_d.phase == asc_pkg::ASC_CONV)
		|-> s_q.active[s_d.cur]) else $error("disabled sequencer started");
	chk_queue_bound: assert property (@(posedge hclk) disable iff (!hresetn) // RQ1
		s_q.cnt[0] <= 4'(DEPTH0) && s_q.cnt[3] <= 4'(DEPTH3)) else $error("queue overfilled");
	chk_conv_sel: assert property (@(posedge hclk) disable iff (!hresetn) // RQ23
		$rose(s_q.conv.busy) && s_q.conv.diff |-> !s_q.conv.sel[0]) else $error("bad pair");
	chk_ris_clear: assert property (@(posedge hclk) disable iff (!hresetn) // RQ14
		s_q.dp_we && s_q.dp_addr == `ASC_OFF_ISC
		|=> (s_q.ris & $past(hwdata[3:0] & ~ris_set)) == 4'h0)
		else $error("pending bit not cleared");
	chk_sac_reset: assert property (@(posedge hclk) disable iff (!hresetn) // RQ21
		$rose(hresetn) |-> s_q.sac == 3'h0 [*2]) else $error("averaging on at reset");
endmodule // asc_sequencer

/* tb/asc_conv_model.sv */
// converter core model answering conversion requests
`timescale 1ns/1ps
module asc_conv_model #(
	parameter int DLY = 6
) (
	input  wire logic                   hclk,
	input  wire logic                   hresetn,
	input  wire asc_pkg::asc_conv_req_t conv_req,
	output logic [9:0]                  conv_result,
	output logic                        conv_done,
	output int                          n_conv,
	output logic [3:0]                  last_sel
);
	logic       busy_q;
	logic [9:0] val;
	int         cnt;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			busy_q <= 1'b0;
			cnt <= 0;
			n_conv <= 0;
			last_sel <= 4'h0;
			val <= 10'h0;
			conv_done <= 1'b0;
			conv_result <= 10'h2aa;
		end else begin
			busy_q <= conv_req.busy;
			if (conv_req.busy && !busy_q) begin
				cnt <= DLY;
				n_conv <= n_conv + 1;
				last_sel <= conv_req.sel;
				conv_done <= 1'b0;
				conv_result <= ~conv_result;
				// zero difference mid code, single-ended code in range
				val <= conv_req.diff ? 10'h1ff : {conv_req.sel, 6'h05};
			end else if (cnt > 1) begin
				cnt <= cnt - 1;
				conv_result <= ~conv_result;
			end else if (cnt == 1) begin
				cnt <= 0;
				conv_done <= 1'b1;
				conv_result <= val;
			end
		end
	end
endmodule // asc_conv_model

/* tb/test_asc_sequencer.sv */
// self-checking bench for the sample sequencer control
`timescale 1ns/1ps
`include "asc_defs.svh"
module test_asc_sequencer;
	logic                   hclk = 1'b0;
	logic                   hresetn = 1'b0;
	logic                   hsel = 1'b0;
	logic [31:0]            haddr = 32'h0;
	logic [1:0]             htrans = 2'h0;
	logic                   hwrite = 1'b0;
	logic [2:0]             hsize = 3'h2;
	logic [31:0]            hwdata = 32'h0;
	logic [11:0]            periph_trig = 12'h0;
	logic                   hready;
	logic                   hreadyout;
	logic                   hresp;
	logic [31:0]            hrdata;
	logic [9:0]             conv_result;
	logic                   conv_done;
	logic                   irq;
	int                     n_conv;
	logic [3:0]             last_sel;
	int                     fails = 0;
	int                     num_checks = 0;
	int                     n0;
	logic [31:0]            r;
	asc_pkg::asc_conv_req_t conv_req;
	assign hready = hreadyout;
	asc_sequencer i_asc_sequencer (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.periph_trig(periph_trig), .conv_result(conv_result), .conv_done(conv_done),
		.conv_req(conv_req), .irq(irq));
	asc_conv_model i_asc_conv_model (.hclk(hclk), .hresetn(hresetn), .conv_req(conv_req),
		.conv_result(conv_result), .conv_done(conv_done), .n_conv(n_conv),
		.last_sel(last_sel));
	initial begin
		forever #20 hclk = ~hclk;
	end
	task automatic final_report();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic hang();
		fails++;
		$display("[ERR] %0t wait bound used up", $time);
		final_report();
	endtask
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cmp1(input logic got, input logic exp);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %0t flag %b expected %b", $time, got, exp);
		end
	endtask
	task automatic wait_rdy();
		int n;
		n = 0;
		@(posedge hclk);
		while (hready !== 1'b1) begin
			if (++n > 20) hang();
			@(posedge hclk);
		end
	endtask
	task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] wd);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {20'h0, a};
		hwrite <= w;
		wait_rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		wait_rdy();
		r = hrdata;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		ahb(1'b1, a, d);
	endtask
	task automatic rd(input logic [11:0] a);
		ahb(1'b0, a, 32'h0);
	endtask
	function automatic logic [11:0] ss(input int n, input int k);
		return 12'(32'h40 + 32 * n + 4 * k);
	endfunction
	task automatic poll(input logic [11:0] a, input logic [31:0] m);
		int n;
		n = 0;
		rd(a);
		while ((r & m) == 32'h0) begin
			if (++n > 200) hang();
			rd(a);
		end
	endtask
	task automatic wait_conv(input int t);
		int n;
		n = 0;
		while (n_conv < t) begin
			if (++n > 500) hang();
			@(posedge hclk);
		end
	endtask
	task automatic t_reset();
		rd(`ASC_OFF_PRI);
		cmp(r, 32'h3210);
		rd(`ASC_OFF_SAC);
		cmp(r, 32'h0);
		rd(ss(0, 3));
		cmp(r, 32'h100);
		rd(12'h0c0);
		cmp(r, 32'h0);
		$display("t_reset done");
	endtask
	task automatic t_disabled();
		wr(ss(1, 0), 32'h3);
		wr(ss(1, 1), 32'h2);
		n0 = n_conv;
		wr(`ASC_OFF_PSSI, 32'h2);
		repeat (40) @(posedge hclk);
		cmp(32'(n_conv), 32'(n0));
		rd(ss(1, 3));
		cmp(r, 32'h100);
		$display("t_disabled done");
	endtask
	task automatic t_seq0();
		logic [3:0] sq [5] = '{4'h1, 4'h2, 4'h1, 4'h0, 4'h2};
		wr(ss(0, 0), 32'h3332_0121);
		wr(ss(0, 1), 32'h6666_0040);
		wr(`ASC_OFF_ACTIVE, 32'h1);
		n0 = n_conv;
		wr(`ASC_OFF_PSSI, 32'h1);
		poll(`ASC_OFF_RIS, 32'h1);
		repeat (80) @(posedge hclk);
		cmp(32'(n_conv - n0), 32'd5);
		rd(ss(0, 3));
		cmp({r[12], r[8], 3'(r[2:0] - r[6:4])}, {27'h0, 5'd5});
		for (int i = 0; i < 5; i++) begin
			rd(ss(0, 2));
			cmp(r, {22'h0, sq[i], 6'h05});
		end
		rd(ss(0, 2));
		rd(`ASC_OFF_USTAT);
		cmp(r, 32'h1);
		repeat (40) @(posedge hclk);
		cmp(32'(n_conv - n0), 32'd5);
		$display("t_seq0 done");
	endtask
	task automatic t_irq();
		rd(`ASC_OFF_ISC);
		cmp(r, 32'h0);
		cmp1(irq, 1'b0);
		wr(`ASC_OFF_IM, 32'h1);
		repeat (2) @(posedge hclk);
		rd(`ASC_OFF_ISC);
		cmp(r, 32'h1);
		cmp1(irq, 1'b1);
		wr(`ASC_OFF_ISC, 32'h0);
		rd(`ASC_OFF_RIS);
		cmp(r, 32'h1);
		wr(`ASC_OFF_ISC, 32'h1);
		repeat (2) @(posedge hclk);
		rd(`ASC_OFF_RIS);
		cmp(r, 32'h0);
		cmp1(irq, 1'b0);
		wr(`ASC_OFF_IM, 32'h0);
		$display("t_irq done");
	endtask
	task automatic t_prio();
		wr(ss(2, 0), 32'h1);
		wr(ss(2, 1), 32'h2);
		wr(`ASC_OFF_PRI, 32'h2013);
		wr(`ASC_OFF_ACTIVE, 32'h6);
		n0 = n_conv;
		wr(`ASC_OFF_PSSI, 32'h6);
		wait_conv(n0 + 1);
		cmp({28'h0, last_sel}, 32'h1);
		wait_conv(n0 + 2);
		cmp({28'h0, last_sel}, 32'h3);
		repeat (40) @(posedge hclk);
		rd(ss(1, 2));
		cmp(r, 32'h0c5);
		rd(ss(2, 2));
		cmp(r, 32'h045);
		rd(`ASC_OFF_RIS);
		cmp(r, 32'h0);
		wr(`ASC_OFF_ACTIVE, 32'h0);
		$display("t_prio done");
	endtask
	task automatic t_diff_avg();
		wr(ss(3, 0), 32'h1);
		wr(ss(3, 1), 32'h7);
		wr(`ASC_OFF_SAC, 32'h2);
		wr(`ASC_OFF_ACTIVE, 32'h8);
		n0 = n_conv;
		wr(`ASC_OFF_PSSI, 32'h8);
		poll(`ASC_OFF_RIS, 32'h8);
		cmp(32'(n_conv - n0), 32'd4);
		cmp({28'h0, last_sel}, 32'h2);
		rd(ss(3, 2));
		cmp(r, 32'h1ff);
		for (int i = 0; i < 2; i++) begin
			wr(`ASC_OFF_ISC, 32'h8);
			wr(`ASC_OFF_PSSI, 32'h8);
			poll(`ASC_OFF_RIS, 32'h8);
		end
		rd(`ASC_OFF_OSTAT);
		cmp(r, 32'h8);
		wr(`ASC_OFF_SAC, 32'h0);
		$display("t_diff_avg done");
	endtask
	task automatic t_always();
		wr(`ASC_OFF_EMUX, 32'h1000);
		n0 = n_conv;
		repeat (40) @(posedge hclk);
		cmp(32'(n_conv), 32'(n0));
		periph_trig <= 12'h001;
		repeat (40) @(posedge hclk);
		cmp1(n_conv - n0 > 0, 1'b1);
		periph_trig <= 12'h000;
		wr(`ASC_OFF_EMUX, 32'hf000);
		n0 = n_conv;
		repeat (100) @(posedge hclk);
		cmp1(n_conv - n0 > 3, 1'b1);
		wr(`ASC_OFF_ACTIVE, 32'h0);
		$display("t_always done");
	endtask
	initial begin
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		t_reset();
		t_disabled();
		t_seq0();
		t_irq();
		t_prio();
		t_diff_avg();
		t_always();
		final_report();
	end
endmodule // test_asc_sequencer
